// file: design/led_driver_serial_latch_error.sv
// Serial load, transfer latch, status capture and error output of an LED sink driver.
`timescale 1ns/1ps
`include "led_driver_cfg.svh"
module led_driver_serial_latch_error
   import led_driver_pkg::*;
#(
   parameter int CHANNELS = `LED_CHANNELS,
   parameter int DETECT_CYCLES = `LED_DETECT_CYCLES
) (
   // Clocks and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   // Serial link, timed by sclk
   input wire logic serial_data_in,
   output logic serial_data_out,
   // Control pins
   input wire logic latch_strobe,
   input wire logic mode_select,
   input wire logic blank,
   input wire logic gsclk_ref,
   // Analog sense inputs
   input wire logic over_temp,
   input wire logic [CHANNELS-1:0] open_compare_low,
   // Channel drive and register views
   output logic [CHANNELS-1:0] channel_output,
   output logic [`LED_DC_LEN-1:0] dot_correction_value,
   output logic thermal_error_flag,
   output logic [CHANNELS-1:0] open_led_flag,
   // Open-drain error pin
   input wire logic error_out_n_i,
   output logic error_out_n_o,
   output logic error_out_n_oe_n
);

   localparam int CNT_W = $clog2(DETECT_CYCLES + 1);
   localparam int SYNC_W = 5 + CHANNELS;

   // Link side state, clocked by sclk.
   logic [`LED_GS_LEN-1:0] shift_q;
   logic [`LED_GS_LEN-1:0] shift_d;
   logic serial_data_out_q;
   logic sid_ack_q;
   logic mode_l;
   logic sid_tgl_l;
   logic load_sid;

   // Core side state, clocked by mclk.
   logic latch_s;
   logic mode_s;
   logic blank_s;
   logic gsclk_s;
   logic hot_s;
   logic [CHANNELS-1:0] cmp_s;
   logic [`LED_GS_LEN-1:0] grayscale_register;
   logic [`LED_DC_LEN-1:0] dot_correction_register;
   logic [`LED_GS_LEN-1:0] status_info_data;
   logic sid_tgl_q;
   latch_state_t latch_state_q;
   logic latch_fall;
   logic thermal_q;
   logic [CHANNELS-1:0] open_q;
   logic [CHANNELS-1:0] open_ready;
   logic [CNT_W-1:0] on_cnt_q [CHANNELS];
   logic err_oe_n_q;
   logic unused_err_in;

   // The pin level is not needed inside; the pad alone reads it.
   assign unused_err_in = error_out_n_i;

   // ---- Link domain ----

   led_sync2 #(
      .WIDTH(2)
   ) u_sync_link (
      .clk(sclk),
      .rst_n(rst_n),
      .d({mode_select, sid_tgl_q}),
      .q({mode_l, sid_tgl_l})
   );

   // A status load costs one sclk edge instead of a shift, and only after the
   // toggle from the core has crossed; the controller gives extra edges for it.
   assign load_sid = (sid_tgl_l != sid_ack_q) && (mode_l == MODE_GRAYSCALE);

   always_comb begin
      if (load_sid) begin
         shift_d = status_info_data;
      end else begin
         shift_d = {shift_q[`LED_GS_LEN-2:0], serial_data_in};
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= '0;
      end else begin
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         sid_ack_q <= 1'b0;
      end else begin
         sid_ack_q <= sid_tgl_l;
      end
   end

   // The tail sits at bit 191 for grayscale frames and bit 95 for dot correction.
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_out_q <= 1'b0;
      end else if (mode_l == MODE_GRAYSCALE) begin
         serial_data_out_q <= shift_d[`LED_GS_LEN-1];
      end else begin
         serial_data_out_q <= shift_d[`LED_DC_LEN-1];
      end
   end

   assign serial_data_out = serial_data_out_q;

   // ---- Core domain ----

   led_sync2 #(
      .WIDTH(SYNC_W)
   ) u_sync_core (
      .clk(mclk),
      .rst_n(rst_n),
      .d({latch_strobe, mode_select, blank, gsclk_ref, over_temp, open_compare_low}),
      .q({latch_s, mode_s, blank_s, gsclk_s, hot_s, cmp_s})
   );

   // The shift register is read across domains without a word crossing: the
   // controller keeps sclk still while the latch is high, and the copy only
   // starts after the latch level has itself crossed, so the word is settled.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         grayscale_register <= '0;
      end else if (latch_s && mode_s == MODE_GRAYSCALE) begin
         grayscale_register <= shift_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dot_correction_register <= '0;
      end else if (latch_s && mode_s == MODE_DOT) begin
         dot_correction_register <= shift_q[`LED_DC_LEN-1:0];
      end
   end

   assign dot_correction_value = dot_correction_register;

   // Tracks the latch pulse so its falling edge can capture status.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         latch_state_q <= LATCH_IDLE;
      end else begin
         case (latch_state_q)
            LATCH_IDLE: begin
               if (latch_s) begin
                  latch_state_q <= LATCH_OPEN;
               end
            end
            LATCH_OPEN: begin
               if (!latch_s) begin
                  latch_state_q <= LATCH_IDLE;
               end
            end
            default: begin
               latch_state_q <= LATCH_IDLE;
            end
         endcase
      end
   end

   assign latch_fall = (latch_state_q == LATCH_OPEN) && !latch_s;

   // Status is frozen between latch pulses, which is what lets the link side
   // read it safely once the toggle has crossed.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_info_data <= '0;
      end else if (latch_fall) begin
         status_info_data <= '0;
         status_info_data[`LED_SID_OPEN_LSB +: CHANNELS] <= open_q;
         status_info_data[`LED_SID_THERM_BIT] <= thermal_q;
         status_info_data[`LED_SID_DC_MSB:`LED_SID_DC_LSB] <= dot_correction_register;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sid_tgl_q <= 1'b0;
      end else if (latch_fall && mode_s == MODE_GRAYSCALE) begin
         sid_tgl_q <= ~sid_tgl_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         thermal_q <= 1'b0;
      end else begin
         thermal_q <= hot_s;
      end
   end

   assign thermal_error_flag = thermal_q;

   // Each channel must be driven for the whole detect delay before a low
   // comparator counts; this hides the slow fall of the pin after turn-on.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            on_cnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (!channel_output[i]) begin
               on_cnt_q[i] <= '0;
            end else if (on_cnt_q[i] != CNT_W'(DETECT_CYCLES)) begin
               on_cnt_q[i] <= on_cnt_q[i] + CNT_W'(1);
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         open_q <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            open_q[i] <= channel_output[i] && (on_cnt_q[i] == CNT_W'(DETECT_CYCLES))
                         && cmp_s[i];
         end
      end
   end

   assign open_led_flag = open_q;

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         open_ready[i] = (on_cnt_q[i] == CNT_W'(DETECT_CYCLES)) && cmp_s[i];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         err_oe_n_q <= 1'b1;
      end else begin
         err_oe_n_q <= ~(thermal_q | ((|open_q) & ~blank_s));
      end
   end

   assign error_out_n_o = 1'b0;
   assign error_out_n_oe_n = err_oe_n_q;

   led_gs_pwm #(
      .CHANNELS(CHANNELS)
   ) u_pwm (
      .mclk(mclk),
      .rst_n(rst_n),
      .gsclk_s(gsclk_s),
      .blank_s(blank_s),
      .gs_flat(grayscale_register),
      .channel_output(channel_output)
   );

   // ---- Checks ----

   property p_gs_copy;
      @(posedge mclk) disable iff (!rst_n)
      (latch_s && mode_s == MODE_GRAYSCALE) |=> (grayscale_register == $past(shift_q));
   endproperty
   a_gs_copy: assert property (p_gs_copy)
      else $error("Grayscale register missed the latched word.");

   property p_dc_copy;
      @(posedge mclk) disable iff (!rst_n)
      (latch_s && mode_s == MODE_DOT) |=> (dot_correction_register == $past(shift_q[95:0]))
         && $stable(grayscale_register);
   endproperty
   a_dc_copy: assert property (p_dc_copy)
      else $error("Dot correction latch went to the wrong register.");

   property p_hold;
      @(posedge mclk) disable iff (!rst_n)
      !latch_s |=> $stable(grayscale_register) && $stable(dot_correction_register);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Data register changed with latch low.");

   property p_shift;
      @(posedge sclk) disable iff (!rst_n)
      !load_sid |=> (shift_q[0] == $past(serial_data_in))
         && (shift_q[191:1] == $past(shift_q[190:0]));
   endproperty
   a_shift: assert property (p_shift)
      else $error("Serial shift lost or misplaced a bit.");

   property p_err_thermal;
      @(posedge mclk) disable iff (!rst_n)
      thermal_q |=> !error_out_n_oe_n;
   endproperty
   a_err_thermal: assert property (p_err_thermal)
      else $error("Error pin released during thermal fault.");

   property p_err_mask;
      @(posedge mclk) disable iff (!rst_n)
      (blank_s && !thermal_q) |=> error_out_n_oe_n;
   endproperty
   a_err_mask: assert property (p_err_mask)
      else $error("Open detection reached error pin while blanked.");

   property p_open_delay;
      @(posedge mclk) disable iff (!rst_n)
      (|(open_q & ~$past(open_q)))
         |-> ((open_q & ~$past(open_q) & ~$past(open_ready)) == '0);
   endproperty
   a_open_delay: assert property (p_open_delay)
      else $error("Open flag raised before the detect delay.");

   property p_status_capture;
      @(posedge mclk) disable iff (!rst_n)
      latch_fall |=> (status_info_data[16] == $past(thermal_q))
         && (status_info_data[15:0] == $past(open_q));
   endproperty
   a_status_capture: assert property (p_status_capture)
      else $error("Status not captured at latch fall.");

   property p_thermal;
      @(posedge mclk) disable iff (!rst_n)
      hot_s ##1 hot_s |-> thermal_error_flag;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("Thermal flag does not follow the sensor.");

endmodule // led_driver_serial_latch_error

// file: design/led_driver_cfg.svh
// Constants for the LED sink driver control logic.
`ifndef LED_DRIVER_CFG_SVH
`define LED_DRIVER_CFG_SVH

`define LED_CHANNELS 16
`define LED_GS_BITS 12
`define LED_DC_BITS 6
`define LED_GS_LEN 192
`define LED_DC_LEN 96
`define LED_GS_MAX 12'hfff
`define LED_SID_OPEN_LSB 0
`define LED_SID_THERM_BIT 16
`define LED_SID_DC_LSB 24
`define LED_SID_DC_MSB 119
`define LED_SYNC_STAGES 2
`define LED_MCLK_PERIOD_PS 5000
`define LED_DETECT_DELAY_NS 1000
`define LED_DETECT_CYCLES \
   (((`LED_DETECT_DELAY_NS * 1000) + `LED_MCLK_PERIOD_PS - 1) / `LED_MCLK_PERIOD_PS)

`endif

// file: design/led_driver_pkg.sv
// Types shared by the LED sink driver control logic.
package led_driver_pkg;

   typedef enum logic {MODE_GRAYSCALE, MODE_DOT} load_mode_t;

   typedef enum logic [1:0] {LATCH_IDLE, LATCH_OPEN} latch_state_t;

   typedef logic [11:0] gs_word_t;

endpackage

// file: design/led_sync2.sv
// Two flip-flop level synchroniser, one bit per lane.
`timescale 1ns/1ps
module led_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule // led_sync2

// file: design/led_gs_pwm.sv
// Grayscale counter and per-channel on/off comparison.
`timescale 1ns/1ps
`include "led_driver_cfg.svh"
module led_gs_pwm
   import led_driver_pkg::*;
#(
   parameter int CHANNELS = `LED_CHANNELS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Synchronised controls
   input wire logic gsclk_s,
   input wire logic blank_s,
   // Grayscale values, channel n in bits 12n+11 to 12n
   input wire logic [CHANNELS*12-1:0] gs_flat,
   // Channel drive
   output logic [CHANNELS-1:0] channel_output
);

   logic gsclk_prev_q;
   gs_word_t cnt_q;
   logic gs_edge;

   function automatic gs_word_t gs_word(input logic [CHANNELS*12-1:0] flat, input int idx);
      gs_word = flat[idx*12 +: 12];
   endfunction

   assign gs_edge = gsclk_s & ~gsclk_prev_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gsclk_prev_q <= 1'b0;
      end else begin
         gsclk_prev_q <= gsclk_s;
      end
   end

   // The count stops at its top so a cycle ends dark until blanking restarts it.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (blank_s) begin
         cnt_q <= '0;
      end else if (gs_edge && cnt_q != `LED_GS_MAX) begin
         cnt_q <= cnt_q + 12'h001;
      end
   end

   // Grayscale values act at once, so a mid-cycle latch changes the running cycle.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         channel_output <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            channel_output[i] <= ~blank_s && (cnt_q < gs_word(gs_flat, i));
         end
      end
   end

   property p_blank_dark;
      @(posedge mclk) disable iff (!rst_n)
      blank_s |=> (channel_output == '0);
   endproperty
   a_blank_dark: assert property (p_blank_dark)
      else $error("Channel on while blanked.");

   property p_blank_cnt;
      @(posedge mclk) disable iff (!rst_n)
      blank_s ##1 blank_s |-> (cnt_q == 12'h000);
   endproperty
   a_blank_cnt: assert property (p_blank_cnt)
      else $error("Grayscale count not held at zero while blanked.");

   property p_zero_dark;
      @(posedge mclk) disable iff (!rst_n)
      (gs_word(gs_flat, 0) == 12'h000) |=> !channel_output[0];
   endproperty
   a_zero_dark: assert property (p_zero_dark)
      else $error("Channel 0 on with zero grayscale value.");

endmodule // led_gs_pwm

// file: tb/led_ctrl_model.sv
// Controller model that drives the serial link and the transfer latch.
`timescale 1ns/1ps
module led_ctrl_model (
   // Core clock for latch timing
   input wire logic mclk,
   // Serial link
   output logic sclk,
   output logic serial_data_in,
   input wire logic serial_data_out,
   // Transfer latch
   output logic latch_strobe
);
   logic [191:0] cap;
   initial begin
      sclk = 1'b0;
      serial_data_in = 1'b0;
      latch_strobe = 1'b0;
      cap = '0;
   end
   // The link clock runs only inside a frame. Afterwards the data line shows the
   // inverse of its last bit, so a stale level is never taken for a driven one.
   task automatic send_bits(input int n, input logic [191:0] d);
      @(negedge mclk);
      #1.7;
      for (int i = n - 1; i >= 0; i--) begin
         // Extra edges beyond the word carry zeros, never an unknown level.
         serial_data_in = (i < 192) ? d[i] : 1'b0;
         #80;
         cap = {cap[190:0], serial_data_out};
         sclk = 1'b1;
         #80;
         sclk = 1'b0;
      end
      serial_data_in = ~serial_data_in;
   endtask
   // The link clock stays still while the latch is high.
   task automatic pulse_latch();
      @(negedge mclk);
      latch_strobe = 1'b1;
      repeat (8) @(negedge mclk);
      latch_strobe = 1'b0;
      repeat (8) @(negedge mclk);
   endtask
endmodule // led_ctrl_model

// file: tb/led_driver_serial_latch_error_tb.sv
// Self-checking bench for serial load, latch, PWM, status and error pin.
`timescale 1ns/1ps
module led_driver_serial_latch_error_tb;
   localparam logic [95:0] DC_A = 96'h0123456789abcdeffedcba98;
   localparam logic [95:0] DC_B = 96'hc3c3c3c3c3c3c3c3c3c3c3c3;
   logic mclk, rst_n, sclk, serial_data_in, serial_data_out, latch_strobe;
   logic mode_select, blank, gsclk_ref, over_temp;
   logic [15:0] open_compare_low, channel_output, open_led_flag;
   logic [95:0] dot_correction_value;
   logic thermal_error_flag, error_out_n_o, error_out_n_oe_n;
   logic [191:0] gs_frame, stat;
   wire err_pad;
   int miscompares = 0;
   int n_checks = 0;

   // Open-drain pin with an external pull-up.
   assign err_pad = error_out_n_oe_n ? 1'b1 : error_out_n_o;

   led_driver_serial_latch_error #(.DETECT_CYCLES(8)) i_dut (
      .mclk(mclk), .rst_n(rst_n), .sclk(sclk),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .latch_strobe(latch_strobe), .mode_select(mode_select), .blank(blank),
      .gsclk_ref(gsclk_ref), .over_temp(over_temp),
      .open_compare_low(open_compare_low), .channel_output(channel_output),
      .dot_correction_value(dot_correction_value),
      .thermal_error_flag(thermal_error_flag), .open_led_flag(open_led_flag),
      .error_out_n_i(err_pad), .error_out_n_o(error_out_n_o),
      .error_out_n_oe_n(error_out_n_oe_n)
   );

   led_ctrl_model i_ctrl (
      .mclk(mclk), .sclk(sclk), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .latch_strobe(latch_strobe)
   );

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [191:0] got, input logic [191:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   task automatic wait_mclk(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // The reference clock is sampled, so each phase lasts four core cycles.
   task automatic gs_tick();
      gsclk_ref = 1'b1;
      wait_mclk(4);
      gsclk_ref = 1'b0;
      wait_mclk(4);
   endtask

   function automatic logic [15:0] on_mask(input int m);
      for (int n = 0; n < 16; n++) begin
         on_mask[n] = (n > m);
      end
   endfunction

   task automatic t_dot_load();
      mode_select = 1'b1;
      wait_mclk(4);
      i_ctrl.send_bits(96, {96'h0, DC_A});
      chk_vec(dot_correction_value, '0, "dot value moved before latch");
      i_ctrl.pulse_latch();
      chk_vec(dot_correction_value, DC_A, "dot value after latch");
   endtask

   task automatic t_hold_chain();
      i_ctrl.send_bits(96, {96'h0, DC_B});
      chk_vec(i_ctrl.cap[95:0], DC_A, "serial out stream");
      chk_vec(dot_correction_value, DC_A, "dot value not held");
      i_ctrl.pulse_latch();
      chk_vec(dot_correction_value, DC_B, "second dot value");
   endtask

   task automatic t_pwm();
      mode_select = 1'b0;
      wait_mclk(4);
      for (int n = 0; n < 16; n++) begin
         gs_frame[12*n +: 12] = 12'(n);
      end
      i_ctrl.send_bits(192, gs_frame);
      chk_vec(channel_output, '0, "outputs on while blanked");
      i_ctrl.pulse_latch();
      blank = 1'b0;
      wait_mclk(8);
      chk_vec(channel_output, on_mask(0), "outputs at count 0");
      for (int m = 1; m <= 16; m++) begin
         gs_tick();
         chk_vec(channel_output, on_mask(m), "outputs after tick");
      end
      blank = 1'b1;
      wait_mclk(6);
      chk_vec(channel_output, '0, "blank did not force off");
      blank = 1'b0;
      wait_mclk(6);
      chk_vec(channel_output, on_mask(0), "counter not reset by blank");
      i_ctrl.send_bits(195, '0);
      chk_vec(i_ctrl.cap, {72'h0, DC_B, 24'h0}, "clean status");
   endtask

   task automatic t_errors();
      open_compare_low = 16'h0009;
      wait_mclk(20);
      chk_vec(open_led_flag, 16'h0008, "open flags");
      chk_bit(err_pad, 1'b0, "pin not pulled on open");
      blank = 1'b1;
      wait_mclk(6);
      chk_bit(err_pad, 1'b1, "open not masked by blank");
      over_temp = 1'b1;
      wait_mclk(6);
      chk_bit(thermal_error_flag, 1'b1, "thermal flag set");
      chk_bit(err_pad, 1'b0, "pin not pulled on thermal");
      blank = 1'b0;
      wait_mclk(20);
      i_ctrl.send_bits(192, gs_frame);
      chk_vec(channel_output, on_mask(0), "outputs moved while shifting");
      i_ctrl.pulse_latch();
      i_ctrl.send_bits(195, '0);
      stat = {72'h0, DC_B, 24'h0};
      stat[16] = 1'b1;
      stat[15:0] = 16'h0008;
      chk_vec(i_ctrl.cap, stat, "error status");
      over_temp = 1'b0;
      wait_mclk(6);
      chk_bit(thermal_error_flag, 1'b0, "thermal flag cleared");
   endtask

   // Whole run is under 200 us; the limit leaves generous margin.
   initial begin
      #500000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      mode_select = 1'b0;
      blank = 1'b1;
      gsclk_ref = 1'b0;
      over_temp = 1'b0;
      open_compare_low = '0;
      gs_frame = '0;
      stat = '0;
      wait_mclk(5);
      rst_n = 1'b1;
      wait_mclk(4);
      t_dot_load();
      t_hold_chain();
      t_pwm();
      t_errors();
      report_and_stop();
   end
endmodule // led_driver_serial_latch_error_tb
